//--- hw/vssr_regs.svh
`ifndef VSSR_REGS_SVH
`define VSSR_REGS_SVH
// Register byte addresses (printed offsets are indices)
`define VSSR_IDX_ORING 8'h30
`define VSSR_IDX_SETPT 8'h31
`define VSSR_IDX_OVLIM 8'h32
`define VSSR_IDX_COMMIT 8'h5D
`define VSSR_ADDR_ORING 12'h0C0
`define VSSR_ADDR_SETPT 12'h0C4
`define VSSR_ADDR_OVLIM 12'h0C8
`define VSSR_ADDR_COMMIT 12'h174
`define VSSR_ADDR_ACTIVE 12'h200
`define VSSR_ADDR_STATUS 12'h204
`define VSSR_ADDR_MASK 12'h208
// Fields
`define VSSR_COMMIT_BIT 0
`define VSSR_THR_HI 7
`define VSSR_THR_LO 3
`define VSSR_DEB_HI 2
`define VSSR_DEB_LO 0
`define VSSR_OV_HI 7
`define VSSR_OV_LO 3
`define VSSR_RSVD_BIT 2
`define VSSR_CNT_HI 1
`define VSSR_CNT_LO 0
// Status bits
`define VSSR_ST_ACC 0
`define VSSR_ST_OFF 1
`define VSSR_ST_OV 2
// Reset values
`define VSSR_SETPT_RST 8'hA5
`define VSSR_ORING_RST 8'h00
`define VSSR_OVLIM_RST 8'h00
// Threshold formula: (base + field) / 128 of full scale
`define VSSR_OV_BASE 10'h059
// Timing
`define VSSR_OV_PERIOD_NS 80000
`define VSSR_CLK_NS 10
`define VSSR_OV_PERIOD_CYC (`VSSR_OV_PERIOD_NS / `VSSR_CLK_NS)
`define VSSR_DEB_UNIT_CYC 100
`endif

//--- hw/vssr_pkg.sv
package vssr_pkg;
   typedef enum logic [1:0] {
      VSSR_OV_IDLE = 2'b00,
      VSSR_OV_ACC = 2'b01,
      VSSR_OV_EVAL = 2'b11
   } vssr_ov_state_t;
   typedef logic [7:0] vssr_byte_t;
endpackage : vssr_pkg

//--- hw/vssr_debounce.sv
`timescale 1ns/1ps
`include "vssr_regs.svh"
module vssr_debounce
   import vssr_pkg::*;
#(
   parameter int UNIT_CYC = `VSSR_DEB_UNIT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Condition and setting
   input wire logic cond,
   input wire logic [2:0] sel,
   // Result
   output logic fire
);
   logic [15:0] cnt_q;
   logic [15:0] lim;
   // Debounce time grows as unit times two to the setting
   assign lim = 16'(UNIT_CYC) << sel;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
      end else if (!cond) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q < lim) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fire <= 1'b0;
      end else begin
         fire <= cond && (cnt_q >= lim);
      end
   end
endmodule : vssr_debounce

//--- hw/vssr_ov_detect.sv
`timescale 1ns/1ps
`include "vssr_regs.svh"
module vssr_ov_detect
   import vssr_pkg::*;
#(
   parameter int PERIOD_CYC = `VSSR_OV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample stream and limits
   input wire logic [9:0] sample,
   input wire logic [9:0] thresh,
   input wire logic [1:0] need,
   // Result
   output logic ov
);
   vssr_ov_state_t st_q;
   logic [31:0] tick_q;
   logic [41:0] sum_q;
   logic [2:0] hits_q;
   logic [41:0] lim;
   logic last;

   assign last = (tick_q == 32'(PERIOD_CYC - 1));
   assign lim = 42'(thresh) * 42'(PERIOD_CYC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= VSSR_OV_IDLE;
         tick_q <= 32'h00000000;
         sum_q <= 42'h0;
      end else begin
         unique case (st_q)
            VSSR_OV_IDLE: begin
               st_q <= VSSR_OV_ACC;
            end
            VSSR_OV_ACC: begin
               sum_q <= sum_q + 42'(sample);
               tick_q <= tick_q + 32'h00000001;
               if (last) begin
                  st_q <= VSSR_OV_EVAL;
               end
            end
            VSSR_OV_EVAL: begin
               sum_q <= 42'h0;
               tick_q <= 32'h00000000;
               st_q <= VSSR_OV_ACC;
            end
            default: st_q <= VSSR_OV_IDLE;
         endcase
      end
   end

   // Average above limit compares the sum with limit times period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hits_q <= 3'h0;
         ov <= 1'b0;
      end else if (st_q == VSSR_OV_EVAL) begin
         if (sum_q > lim) begin
            if (hits_q < 3'({1'b0, need})) begin
               hits_q <= hits_q + 3'h1;
            end
            ov <= (hits_q >= 3'({1'b0, need}));
         end else begin
            hits_q <= 3'h0;
            ov <= 1'b0;
         end
      end
   end
endmodule : vssr_ov_detect

//--- hw/vssr_top.sv
// What this block does
// - Set accurate oring flag when sense difference reaches programmed threshold.
// - Disable oring switch only after fast condition persists full debounce.
// - Hold 8-bit remote setpoint spanning 0% to 155% of nominal.
// - Each setpoint step adds 0.6% of nominal.
// - Setpoint resets to 0xA5, meaning 100% of nominal.
// - Setpoint writes go to shadow; active value stays until commit.
// - Host sets commit bit 0 at 0x5D; device copies shadow to active.
// - Local overvoltage field is 5 bits in bits 7 to 3.
// - Field zero is 107.7%, each step adds 1.21% of nominal.
// - Threshold equals (89 plus field) over 128 of 1.55 V full scale.
// - Overvoltage flag when 80 us average exceeds threshold.
// - Two-bit count needs one to four consecutive periods above threshold.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "vssr_regs.svh"
module vssr_top
   import vssr_pkg::*;
#(
   parameter int OV_PERIOD_CYC = `VSSR_OV_PERIOD_CYC,
   parameter int DEB_UNIT_CYC = `VSSR_DEB_UNIT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sense inputs, 10-bit codes of 1.55 V full scale
   input wire logic [9:0] current_sense_pos,
   input wire logic [9:0] current_sense_neg,
   input wire logic [9:0] local_sense_input,
   input wire logic fast_oring_cond,
   // Results
   output logic [7:0] active_setpoint,
   output logic accurate_oring_flag,
   output logic oring_switch_en,
   output logic overvoltage_protection_flag,
   output logic irq
);
   vssr_byte_t oring_q;
   vssr_byte_t setpt_shadow_q;
   vssr_byte_t setpt_active_q;
   vssr_byte_t ovlim_q;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic [9:0] code_pin [3];
   logic [9:0] code_held [3];
   logic fast_s1_q, fast_s2_q;
   logic wr, rd_ok;
   logic commit;
   logic [9:0] diff;
   logic [9:0] oring_thr;
   logic [9:0] ov_thr;
   logic deb_fire;
   logic ov_raw;
   logic acc_q, off_q, ov_q;
   logic [2:0] events;

   // Sense code lanes: positive, negative, local
   assign code_pin[0] = current_sense_pos;
   assign code_pin[1] = current_sense_neg;
   assign code_pin[2] = local_sense_input;

   // Code bits may cross in different cycles; take a code
   // only when two synchronised samples in a row agree
   for (genvar i = 0; i < 3; i++) begin : g_code
      logic [9:0] s1_q;
      logic [9:0] s2_q;
      logic [9:0] s3_q;
      logic [9:0] held_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_q <= 10'h000;
            s2_q <= 10'h000;
            s3_q <= 10'h000;
            held_q <= 10'h000;
         end else begin
            s1_q <= code_pin[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               held_q <= s2_q;
            end
         end
      end
      assign code_held[i] = held_q;
   end

   // Fast condition synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_s1_q <= 1'b0;
         fast_s2_q <= 1'b0;
      end else begin
         fast_s1_q <= fast_oring_cond;
         fast_s2_q <= fast_s1_q;
      end
   end

   // APB decode, zero wait states
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign commit = wr && (paddr == `VSSR_ADDR_COMMIT)
      && pwdata[`VSSR_COMMIT_BIT];

   always_comb begin
      rd_ok = 1'b1;
      unique case (paddr)
         `VSSR_ADDR_ORING, `VSSR_ADDR_SETPT, `VSSR_ADDR_OVLIM,
         `VSSR_ADDR_COMMIT, `VSSR_ADDR_ACTIVE, `VSSR_ADDR_STATUS,
         `VSSR_ADDR_MASK: rd_ok = 1'b1;
         default: rd_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !rd_ok;

   // Oring switch settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oring_q <= `VSSR_ORING_RST;
      end else if (wr && paddr == `VSSR_ADDR_ORING) begin
         oring_q <= pwdata[7:0];
      end
   end

   // Local limit, reserved bit is plain storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovlim_q <= `VSSR_OVLIM_RST;
      end else if (wr && paddr == `VSSR_ADDR_OVLIM) begin
         ovlim_q <= pwdata[7:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 3'h0;
      end else if (wr && paddr == `VSSR_ADDR_MASK) begin
         mask_q <= pwdata[2:0];
      end
   end

   // Shadow setpoint, written by software only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpt_shadow_q <= `VSSR_SETPT_RST;
      end else if (wr && paddr == `VSSR_ADDR_SETPT) begin
         setpt_shadow_q <= pwdata[7:0];
      end
   end

   // Active setpoint changes only on commit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpt_active_q <= `VSSR_SETPT_RST;
      end else if (commit) begin
         setpt_active_q <= setpt_shadow_q;
      end
   end
   // Each code step is 0.6% of nominal at the regulator
   assign active_setpoint = setpt_active_q;

   // Accurate oring comparison
   assign diff = (code_held[0] > code_held[1])
      ? (code_held[0] - code_held[1]) : 10'h000;
   assign oring_thr = {5'h00,
      oring_q[`VSSR_THR_HI:`VSSR_THR_LO]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 1'b0;
      end else begin
         // Negative difference never reaches a zero threshold
         acc_q <= (code_held[0] >= code_held[1])
            && (diff >= oring_thr);
      end
   end
   assign accurate_oring_flag = acc_q;

   vssr_debounce #(
      .UNIT_CYC(DEB_UNIT_CYC)
   ) u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .cond(fast_s2_q),
      .sel(oring_q[`VSSR_DEB_HI:`VSSR_DEB_LO]),
      .fire(deb_fire)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_q <= 1'b0;
      end else begin
         off_q <= deb_fire;
      end
   end
   assign oring_switch_en = !off_q;

   // Threshold in 1.55 V / 1024 codes: (base + field) * 8
   assign ov_thr = (`VSSR_OV_BASE
      + {5'h00, ovlim_q[`VSSR_OV_HI:`VSSR_OV_LO]}) << 3;

   vssr_ov_detect #(
      .PERIOD_CYC(OV_PERIOD_CYC)
   ) u_ov (
      .pclk(pclk),
      .presetn(presetn),
      .sample(code_held[2]),
      .thresh(ov_thr),
      .need(ovlim_q[`VSSR_CNT_HI:`VSSR_CNT_LO]),
      .ov(ov_raw)
   );
   assign overvoltage_protection_flag = ov_raw;

   // Rising edges become events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_q <= 1'b0;
      end else begin
         ov_q <= ov_raw;
      end
   end
   logic acc_d1_q, off_d1_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_d1_q <= 1'b0;
         off_d1_q <= 1'b0;
      end else begin
         acc_d1_q <= acc_q;
         off_d1_q <= off_q;
      end
   end
   assign events = {ov_raw && !ov_q, off_q && !off_d1_q,
      acc_q && !acc_d1_q};

   // Sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 3'h0;
      end else if (wr && paddr == `VSSR_ADDR_STATUS) begin
         status_q <= (status_q & ~pwdata[2:0]) | events;
      end else begin
         status_q <= status_q | events;
      end
   end
   assign irq = |(status_q & mask_q);

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `VSSR_ADDR_ORING: prdata <= {24'h000000, oring_q};
            `VSSR_ADDR_SETPT: prdata <= {24'h000000, setpt_shadow_q};
            `VSSR_ADDR_OVLIM: prdata <= {24'h000000, ovlim_q};
            `VSSR_ADDR_ACTIVE: prdata <= {24'h000000, setpt_active_q};
            `VSSR_ADDR_STATUS: prdata <= {29'h00000000, status_q};
            `VSSR_ADDR_MASK: prdata <= {29'h00000000, mask_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule : vssr_top

//--- verification/vssr_checker.sv
`timescale 1ns/1ps
`include "vssr_regs.svh"
module vssr_checker #(
   parameter int DEB_UNIT_CYC = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Sense and results
   input wire logic [9:0] current_sense_pos,
   input wire logic [9:0] current_sense_neg,
   input wire logic fast_oring_cond,
   input wire logic [7:0] active_setpoint,
   input wire logic accurate_oring_flag,
   input wire logic oring_switch_en,
   input wire logic irq
);
   logic wr, mapped, reach, cond_q;
   logic [7:0] shadow_q, oring_q;
   logic [2:0] mask_q;
   logic [15:0] run_q;
   logic [9:0] pos_q, neg_q;
   logic steady;
   assign wr = psel && penable && pwrite;
   assign mapped = paddr inside {`VSSR_ADDR_ORING, `VSSR_ADDR_SETPT,
      `VSSR_ADDR_OVLIM, `VSSR_ADDR_COMMIT, `VSSR_ADDR_ACTIVE,
      `VSSR_ADDR_STATUS, `VSSR_ADDR_MASK};
   assign reach = {1'b0, current_sense_pos} >=
      {1'b0, current_sense_neg} + {6'h00, oring_q[7:3]};
   // Codes pass sync and agreement stages in the design
   assign steady = (current_sense_pos == pos_q)
      && (current_sense_neg == neg_q);
   // Register copies and length of the latest fast-condition run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_q <= 8'hA5;
         oring_q <= 8'h00;
         mask_q <= 3'h0;
         cond_q <= 1'b0;
         run_q <= 16'h0000;
         pos_q <= 10'h000;
         neg_q <= 10'h000;
      end else begin
         cond_q <= fast_oring_cond;
         pos_q <= current_sense_pos;
         neg_q <= current_sense_neg;
         if (wr && paddr == `VSSR_ADDR_SETPT) shadow_q <= pwdata[7:0];
         if (wr && paddr == `VSSR_ADDR_ORING) oring_q <= pwdata[7:0];
         if (wr && paddr == `VSSR_ADDR_MASK) mask_q <= pwdata[2:0];
         if (fast_oring_cond && !cond_q) run_q <= 16'h0001;
         else if (fast_oring_cond) run_q <= run_q + 16'h0001;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_commit;
      wr && paddr == `VSSR_ADDR_COMMIT && pwdata[0];
   endsequence
   a_err_unmapped: assert property (s_access |-> pslverr == !mapped)
      else $error("pslverr wrong");
   a_unmapped_zero: assert property (
      psel && penable && !pwrite && !mapped |-> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_shadow_only: assert property (
      wr && paddr == `VSSR_ADDR_SETPT |=> $stable(active_setpoint))
      else $error("setpoint moved without commit");
   a_commit_copies: assert property (
      s_commit |=> active_setpoint == shadow_q)
      else $error("commit did not load setpoint");
   a_oring_reach: assert property (
      (reach && steady) [*6] |-> accurate_oring_flag)
      else $error("accurate flag missing");
   a_oring_short: assert property (
      (!reach && steady) [*6] |-> !accurate_oring_flag)
      else $error("accurate flag early");
   a_switch_debounce: assert property (
      $fell(oring_switch_en)
      |-> int'(run_q) >= (DEB_UNIT_CYC << oring_q[2:0]))
      else $error("switch off before debounce");
   a_irq_masked: assert property ((mask_q == 3'h0) [*2] |-> !irq)
      else $error("irq while masked");
endmodule : vssr_checker

bind vssr_top vssr_checker #(.DEB_UNIT_CYC(DEB_UNIT_CYC)) chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pslverr, .current_sense_pos, .current_sense_neg, .fast_oring_cond,
   .active_setpoint, .accurate_oring_flag, .oring_switch_en, .irq
);

//--- verification/testbench.sv
`timescale 1ns/1ps
`include "vssr_regs.svh"
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic fast_oring_cond, accurate_oring_flag, oring_switch_en;
   logic overvoltage_protection_flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, v;
   logic [9:0] current_sense_pos, current_sense_neg, local_sense_input;
   logic [7:0] active_setpoint;
   logic [31:0] exp_q[$];
   int errors, comparisons;
   vssr_top #(.OV_PERIOD_CYC(20), .DEB_UNIT_CYC(4)) dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .current_sense_pos, .current_sense_neg, .local_sense_input,
      .fast_oring_cond, .active_setpoint, .accurate_oring_flag,
      .oring_switch_en, .overvoltage_protection_flag, .irq);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   function automatic logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(logic [11:0] a, logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, rnd());
   endtask : rd
   // Scoreboard: completed reads against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1)
         check("prdata", prdata, exp_q.pop_front());
   end
   initial begin
      repeat (6000) @(posedge pclk);
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      seed = 32'h0000004F;
      {presetn, psel, penable, pwrite, fast_oring_cond} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      {current_sense_pos, current_sense_neg, local_sense_input} = 30'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`VSSR_ADDR_SETPT, 32'hA5);
      rd(`VSSR_ADDR_ACTIVE, 32'hA5);
      rd(12'h0FC, 32'h0);
      $display("reset test done");
      wr(`VSSR_ADDR_SETPT, 32'h10);
      wr(`VSSR_ADDR_SETPT, 32'hFF);
      rd(`VSSR_ADDR_ACTIVE, 32'hA5);
      rd(`VSSR_ADDR_SETPT, 32'hFF);
      wr(`VSSR_ADDR_COMMIT, 32'h1);
      rd(`VSSR_ADDR_ACTIVE, 32'hFF);
      rd(`VSSR_ADDR_COMMIT, 32'h0);
      repeat (4) begin
         v = rnd();
         wr(`VSSR_ADDR_OVLIM, v);
         rd(`VSSR_ADDR_OVLIM, {24'h0, v[7:0]});
      end
      $display("register test done");
      wr(`VSSR_ADDR_MASK, 32'h7);
      wr(`VSSR_ADDR_STATUS, 32'h7);
      wr(`VSSR_ADDR_ORING, 32'h28);
      current_sense_pos <= 10'h064;
      current_sense_neg <= 10'h060;
      repeat (8) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h0);
      current_sense_neg <= 10'h05F;
      repeat (8) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h1);
      wr(`VSSR_ADDR_STATUS, 32'h1);
      wr(`VSSR_ADDR_ORING, 32'h2A);
      fast_oring_cond <= 1'b1;
      repeat (10) @(posedge pclk);
      fast_oring_cond <= 1'b0;
      repeat (10) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h0);
      fast_oring_cond <= 1'b1;
      repeat (30) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h2);
      #1 check("irq", {31'h0, irq}, 32'h1);
      wr(`VSSR_ADDR_MASK, 32'h0);
      #1 check("irq", {31'h0, irq}, 32'h0);
      $display("oring test done");
      wr(`VSSR_ADDR_MASK, 32'h7);
      wr(`VSSR_ADDR_STATUS, 32'h7);
      wr(`VSSR_ADDR_OVLIM, 32'h5B);
      local_sense_input <= 10'h320;
      repeat (100) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h0);
      wr(`VSSR_ADDR_OVLIM, 32'h53);
      repeat (60) @(posedge pclk);
      rd(`VSSR_ADDR_STATUS, 32'h0);
      for (int i = 0; i < 100 && !overvoltage_protection_flag; i++) begin
         @(posedge pclk);
      end
      check("ov_flag", {31'h0, overvoltage_protection_flag},
         32'h1);
      rd(`VSSR_ADDR_STATUS, 32'h4);
      $display("overvoltage test done");
      end_of_test();
   end
endmodule : testbench
